// *** verilog/ipc_pkg.sv ***
// package for the interrupt posted/clear register block
// holds register indices, byte addresses, field positions and reset values
package ipc_pkg;

    // the bus address width of this block
    localparam int unsigned AXI_ADDR_W = 12;
    localparam int unsigned SRC_W      = 8;

    // printed register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CLEAR_0 = 8'hda;
    localparam logic [7:0] IDX_CLEAR_1 = 8'hdb;
    localparam logic [7:0] IDX_MASK_1  = 8'hdf;
    localparam logic [7:0] IDX_MASK_0  = 8'he0;
    localparam logic [7:0] IDX_SW_EN   = 8'he1;

    localparam logic [11:0] ADDR_CLEAR_0 = {2'b00, IDX_CLEAR_0, 2'b00};
    localparam logic [11:0] ADDR_CLEAR_1 = {2'b00, IDX_CLEAR_1, 2'b00};
    localparam logic [11:0] ADDR_MASK_1  = {2'b00, IDX_MASK_1, 2'b00};
    localparam logic [11:0] ADDR_MASK_0  = {2'b00, IDX_MASK_0, 2'b00};
    localparam logic [11:0] ADDR_SW_EN   = {2'b00, IDX_SW_EN, 2'b00};

    // field position of the software post enable bit
    localparam int unsigned SW_EN_BIT = 0;

    // values after reset
    localparam logic [7:0] RST_POSTED = 8'h00;
    localparam logic [7:0] RST_MASK   = 8'h00;
    localparam logic       RST_SW_EN  = 1'b0;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// *** verilog/ipc_posted_bank.sv ***
// one bank of eight posted-interrupt flags
// assumes write strobe and data come from the register slave in the same clock
`timescale 1ns/10ps
module ipc_posted_bank
#(
    parameter int unsigned WIDTH = ipc_pkg::SRC_W
)
(
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // hardware source events
    input  wire logic [WIDTH-1:0] src_event,
    // software access
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             sw_post_enable,
    // flags
    output logic      [WIDTH-1:0] posted
);
    import ipc_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] posted;
    } ipc_bank_state_t;

    ipc_bank_state_t s_q;
    ipc_bank_state_t s_d;

    // per-bit next value: hardware event always wins over a software clear
    always_comb
    begin
        s_d = s_q;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (src_event[i])
                s_d.posted[i] = 1'b1;
            else if (wr_en && sw_post_enable)
                s_d.posted[i] = s_q.posted[i] | wr_data[i];
            else if (wr_en)
                s_d.posted[i] = s_q.posted[i] & wr_data[i];
        end
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '{posted: RST_POSTED[WIDTH-1:0]};
        else
            s_q <= s_d;
    end

    assign posted = s_q.posted;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_sw_clear_bit: assert property (wr_en && !sw_post_enable && !wr_data[0] && !src_event[0] |=> !posted[0])
        else $error("software clear did not clear bit 0");
    a_sw_post_bit: assert property (wr_en && sw_post_enable && wr_data[WIDTH-1] |=> posted[WIDTH-1])
        else $error("software post did not set top bit");
    a_no_effect: assert property (wr_en && (sw_post_enable != wr_data[1]) && !src_event[1]
                                  |=> posted[1] == $past(posted[1]))
        else $error("no-effect write changed bit 1");
    a_event_wins: assert property (src_event[0] |=> posted[0])
        else $error("hardware event lost");
    c_event_vs_clear: cover property (src_event[0] && wr_en && !sw_post_enable && !wr_data[0]);
endmodule

// *** verilog/ipc_top.sv ***
// interrupt posted/clear registers behind an AXI4-Lite slave
// assumes a single clock, a master that keeps the AXI4-Lite handshake,
// and hardware sources that pulse an event line for each interrupt
// software sees byte lane 0 only; upper data bits read as zero
// pending outputs go to an outside priority stage; this block only masks them
// enable and masks live here because both decide what a write or a flag means
//
// Summary of operation
// - reading a clear register returns posted flags
// - write 0 with enable off clears flag
// - clearing an unposted flag changes nothing
// - write 1 with enable on posts flag
// - write 1 with enable off does nothing
// - write 0 with enable on does nothing
// - bank 0 holds serial, timer, sense sources
// - bank 1 holds USB and timer sources
// - software enable bit 0, resets to 0
// - masked sources still post; mask gates pending
`timescale 1ns/10ps
module ipc_top
(
    // clock and reset
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    // write address channel
    input  wire logic [ipc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    // write data channel
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    // write response channel
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    // read address channel
    input  wire logic [ipc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    // read data channel
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    // source events: bank 0 is i2c, sleep, spi, gpio, timer0, sense, analog, supply
    input  wire logic [ipc_pkg::SRC_W-1:0]      src_event_0,
    // bank 1 is endpoint 3..0, start of frame, bus reset, timer2, timer1
    input  wire logic [ipc_pkg::SRC_W-1:0]      src_event_1,
    // posted flags and their masked pending view
    output logic [ipc_pkg::SRC_W-1:0]           posted_0,
    output logic [ipc_pkg::SRC_W-1:0]           posted_1,
    output logic [ipc_pkg::SRC_W-1:0]           pending_0,
    output logic [ipc_pkg::SRC_W-1:0]           pending_1,
    output logic                                software_post_enable
);
    import ipc_pkg::*;

    typedef struct packed {
        logic                  aw_got;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic                  w_got;
        logic [7:0]            wdata;
        logic                  wstrb0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic                  sw_en;
        logic [SRC_W-1:0]      mask_0;
        logic [SRC_W-1:0]      mask_1;
    } ipc_top_state_t;

    ipc_top_state_t   s_q;
    ipc_top_state_t   s_d;
    logic             wr_clear_0;
    logic             wr_clear_1;
    logic [SRC_W-1:0] bank_posted_0;
    logic [SRC_W-1:0] bank_posted_1;

    // both banks share one cell so the clear/post table lives in one place
    ipc_posted_bank #(.WIDTH(SRC_W)) u_bank_0
    (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .src_event      (src_event_0),
        .wr_en          (wr_clear_0),
        .wr_data        (s_q.wdata),
        .sw_post_enable (s_q.sw_en),
        .posted         (bank_posted_0)
    );

    ipc_posted_bank #(.WIDTH(SRC_W)) u_bank_1
    (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .src_event      (src_event_1),
        .wr_en          (wr_clear_1),
        .wr_data        (s_q.wdata),
        .sw_post_enable (s_q.sw_en),
        .posted         (bank_posted_1)
    );

    // ready only while the holding slot is empty and no response is owed
    // refusing a second write until the response is taken keeps one write in flight
    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;

    // bus slave and register file next state
    always_comb
    begin
        s_d        = s_q;
        wr_clear_0 = 1'b0;
        wr_clear_1 = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.w_got  = 1'b1;
            s_d.wdata  = s_axi_wdata[7:0];
            s_d.wstrb0 = s_axi_wstrb[0];
        end
        // perform the write once address and data are both held
        // the stored enable is used, so an enable write only changes later writes
        if (s_q.aw_got && s_q.w_got)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = RESP_OKAY;
            // only byte lane 0 carries data; a write without it stores nothing
            unique case (s_q.awaddr[AXI_ADDR_W-1:2])
                ADDR_CLEAR_0[11:2]: wr_clear_0 = s_q.wstrb0;
                ADDR_CLEAR_1[11:2]: wr_clear_1 = s_q.wstrb0;
                ADDR_SW_EN[11:2]:
                begin
                    if (s_q.wstrb0)
                        s_d.sw_en = s_q.wdata[SW_EN_BIT];
                end
                ADDR_MASK_0[11:2]:
                begin
                    if (s_q.wstrb0)
                        s_d.mask_0 = s_q.wdata;
                end
                ADDR_MASK_1[11:2]:
                begin
                    if (s_q.wstrb0)
                        s_d.mask_1 = s_q.wdata;
                end
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end
        // a response leaves only on the edge at which the master accepts it
        if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;
        if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;
        // read: sample the register in the address cycle, answer next cycle
        // a read and a write-apply in one cycle: the read sees the flags from before
        // unmapped addresses answer with an error and read as zero
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr[AXI_ADDR_W-1:2])
                ADDR_CLEAR_0[11:2]: s_d.rdata[SRC_W-1:0] = bank_posted_0;
                ADDR_CLEAR_1[11:2]: s_d.rdata[SRC_W-1:0] = bank_posted_1;
                ADDR_SW_EN[11:2]:   s_d.rdata[SW_EN_BIT] = s_q.sw_en;
                ADDR_MASK_0[11:2]:  s_d.rdata[SRC_W-1:0] = s_q.mask_0;
                ADDR_MASK_1[11:2]:  s_d.rdata[SRC_W-1:0] = s_q.mask_1;
                default:            s_d.rresp = RESP_SLVERR;
            endcase
        end
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q        <= '0;
            s_q.sw_en  <= RST_SW_EN;
            s_q.mask_0 <= RST_MASK;
            s_q.mask_1 <= RST_MASK;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs
    // response and read data come from flops, so they hold while the master stalls
    assign s_axi_bvalid         = s_q.bvalid;
    assign s_axi_bresp          = s_q.bresp;
    assign s_axi_rvalid         = s_q.rvalid;
    assign s_axi_rdata          = s_q.rdata;
    assign s_axi_rresp          = s_q.rresp;
    assign posted_0             = bank_posted_0;
    assign posted_1             = bank_posted_1;
    // masking never blocks posting, only the pending view
    assign pending_0            = bank_posted_0 & s_q.mask_0;
    assign pending_1            = bank_posted_1 & s_q.mask_1;
    assign software_post_enable = s_q.sw_en;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_read_clear0: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_CLEAR_0
                                    |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(bank_posted_0)})
        else $error("clear register 0 read wrong");
    a_read_clear1: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_CLEAR_1
                                    |=> s_axi_rdata == {24'h000000, $past(bank_posted_1)})
        else $error("clear register 1 read wrong");
    a_clear_write: assert property (s_q.aw_got && s_q.w_got && s_q.wstrb0 && s_q.awaddr == ADDR_CLEAR_0
                                    && !s_q.sw_en && !s_q.wdata[7] && !src_event_0[7] |=> !posted_0[7])
        else $error("clear write left flag set");
    a_post_write: assert property (s_q.aw_got && s_q.w_got && s_q.wstrb0 && s_q.awaddr == ADDR_CLEAR_1
                                   && s_q.sw_en && s_q.wdata[0] |=> posted_1[0])
        else $error("post write did not set flag");
    a_quiet_keep: assert property (!(s_q.aw_got && s_q.w_got) && src_event_0 == 8'h00
                                   |=> posted_0 == $past(posted_0))
        else $error("flags changed without cause");
    a_enable_write: assert property (s_q.aw_got && s_q.w_got && s_q.wstrb0 && s_q.awaddr == ADDR_SW_EN
                                     |=> software_post_enable == $past(s_q.wdata[0]))
        else $error("enable bit not stored");
    a_mask_gate: assert property (src_event_1[3] |=> posted_1[3] && (pending_1[3] == s_q.mask_1[3]))
        else $error("masked event not posted");
    a_write_resp: assert property (s_q.aw_got && s_q.w_got |=> s_axi_bvalid ##0 !s_axi_awready)
        else $error("write response late");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");

    // whole-bank views: every bit of a clearing or posting write, no events in flight
    a_clear_bank0: assert property (
        wr_clear_0 && !s_q.sw_en && src_event_0 == 8'h00 |=> posted_0 == ($past(posted_0) & $past(s_q.wdata)))
        else $error("clearing write to bank 0 wrong");
    a_clear_bank1: assert property (
        wr_clear_1 && !s_q.sw_en && src_event_1 == 8'h00 |=> posted_1 == ($past(posted_1) & $past(s_q.wdata)))
        else $error("clearing write to bank 1 wrong");
    a_post_bank0: assert property (
        wr_clear_0 && s_q.sw_en && src_event_0 == 8'h00 |=> posted_0 == ($past(posted_0) | $past(s_q.wdata)))
        else $error("posting write to bank 0 wrong");
    a_post_bank1: assert property (
        wr_clear_1 && s_q.sw_en && src_event_1 == 8'h00 |=> posted_1 == ($past(posted_1) | $past(s_q.wdata)))
        else $error("posting write to bank 1 wrong");

    // every event bit lands on its own flag, whatever software does in that cycle
    a_event_bank0: assert property (
        src_event_0 != 8'h00 |=> (posted_0 & $past(src_event_0)) == $past(src_event_0))
        else $error("bank 0 event not posted");
    a_event_bank1: assert property (
        src_event_1 != 8'h00 |=> (posted_1 & $past(src_event_1)) == $past(src_event_1))
        else $error("bank 1 event not posted");

    // reset, enable and masks; the reset check must stay armed while reset is low
    a_reset_state: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> posted_0 == 8'h00 && posted_1 == 8'h00 && pending_0 == 8'h00 && pending_1 == 8'h00
                     && !software_post_enable)
        else $error("state not cleared by reset");
    a_strobe_off: assert property (
        s_q.aw_got && s_q.w_got && !s_q.wstrb0 |=> $stable(software_post_enable) && $stable(s_q.mask_0))
        else $error("write without low byte strobe stored data");
    a_read_enable: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_SW_EN
        |=> s_axi_rdata == {31'h0, $past(software_post_enable)})
        else $error("enable register read wrong");
    a_read_mask0: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_MASK_0
        |=> s_axi_rdata == {24'h000000, $past(s_q.mask_0)})
        else $error("mask register 0 read wrong");
    a_mask_write: assert property (
        s_q.aw_got && s_q.w_got && s_q.wstrb0 && s_q.awaddr == ADDR_MASK_1 |=> s_q.mask_1 == $past(s_q.wdata))
        else $error("mask register 1 not stored");
    a_pend_bank0: assert property (
        s_q.mask_0 == 8'h00 |-> pending_0 == 8'h00)
        else $error("masked bank 0 flag became pending");
    a_pend_bank1: assert property (
        s_q.mask_1 == 8'h00 |-> pending_1 == 8'h00)
        else $error("masked bank 1 flag became pending");

    // handshake refusals that keep one write and one read in flight, and zero data on an error read
    a_aw_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response owed");
    a_ar_block: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data owed");
    a_read_slverr: assert property (
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    // scenarios the bench is expected to reach
    c_sw_post: cover property (wr_clear_0 && s_q.sw_en && s_q.wdata != 8'h00);
    c_sw_clear: cover property (wr_clear_1 && !s_q.sw_en ##1 posted_1 == 8'h00);
    c_bad_addr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_post_read: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata[SRC_W-1:0] != 8'h00);
endmodule

// *** tb/ipc_top_tb.sv ***
// self-checking bench for the interrupt posted/clear register block
// assumes ipc_pkg constants; a bench model of flags, masks and enable is compared at every result
`timescale 1ns/10ps
module ipc_top_tb;
    import ipc_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, sw_en;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [7:0]  ev0, ev1, po0, po1, pe0, pe1;
    int          err_total, cmp_count, pm[2], mk[2], hold[2], en, i, k;

    ipc_top i_ipc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_event_0(ev0),
        .src_event_1(ev1), .posted_0(po0), .posted_1(po1), .pending_0(pe0), .pending_1(pe1),
        .software_post_enable(sw_en));

    // 10 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // a wait that runs out its bound ends the run through the report
    task automatic tick(inout int n);
        n++;
        if (n > 50)
        begin
            err_total++;
            $display("[ERR] handshake wait expected 50 cycles seen timeout");
            results();
        end
    endtask

    task automatic chk_state;
        chk("posted_0", pm[0], {24'h0, po0});
        chk("posted_1", pm[1], {24'h0, po1});
        chk("pending_0", pm[0] & mk[0], {24'h0, pe0});
        chk("pending_1", pm[1] & mk[1], {24'h0, pe1});
        chk("sw_enable", en, {31'h0, sw_en});
    endtask

    // model of one register write; enable seen is the value before the write
    function automatic logic [1:0] mwr(input logic [11:0] a, input int d, input logic s);
        int b;
        case (a)
            ADDR_CLEAR_0: b = 0;
            ADDR_CLEAR_1: b = 1;
            ADDR_MASK_0: begin if (s) mk[0] = d & 255; return RESP_OKAY; end
            ADDR_MASK_1: begin if (s) mk[1] = d & 255; return RESP_OKAY; end
            ADDR_SW_EN:  begin if (s) en = d & 1; return RESP_OKAY; end
            default: return RESP_SLVERR;
        endcase
        if (s)
            pm[b] = (en != 0 ? (pm[b] | d) : (pm[b] & d)) & 255;
        pm[b] = pm[b] | hold[b];
        return RESP_OKAY;
    endfunction

    function automatic int mrd(input logic [11:0] a);
        case (a)
            ADDR_CLEAR_0: return pm[0];
            ADDR_CLEAR_1: return pm[1];
            ADDR_MASK_0:  return mk[0];
            ADDR_MASK_1:  return mk[1];
            ADDR_SW_EN:   return en;
            default:      return 0;
        endcase
    endfunction

    // readies are stable between edges, so they are looked at on the falling edge
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        logic ta, tw, ad, wd;
        logic [1:0] er;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge aclk);
            if (ta) begin awvalid <= 1'b0; ad = 1'b1; end
            if (tw) begin wvalid <= 1'b0; wd = 1'b1; end
            tick(n);
        end
        er = mwr(a, int'(d[7:0]), s[0]);
        forever
        begin
            @(negedge aclk);
            if (bvalid === 1'b1)
                break;
            tick(n);
        end
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        chk_state();
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a);
        int n;
        logic [1:0] er;
        n = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever
        begin
            @(negedge aclk);
            if (arready === 1'b1) break;
            tick(n);
        end
        @(posedge aclk);
        arvalid <= 1'b0;
        forever
        begin
            @(negedge aclk);
            if (rvalid === 1'b1) break;
            tick(n);
        end
        chk("rdata", mrd(a), rdata);
        er = (a inside {ADDR_CLEAR_0, ADDR_CLEAR_1, ADDR_MASK_0, ADDR_MASK_1, ADDR_SW_EN})
             ? RESP_OKAY : RESP_SLVERR;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    // one-cycle hardware events on both banks
    task automatic pulse(input logic [7:0] e0, input logic [7:0] e1);
        @(posedge aclk);
        ev0 <= e0;
        ev1 <= e1;
        @(posedge aclk);
        ev0 <= 8'h00;
        ev1 <= 8'h00;
        pm[0] |= e0;
        pm[1] |= e1;
        #1 chk_state();
    endtask

    task automatic rd_all;
        axi_rd(ADDR_CLEAR_0); axi_rd(ADDR_CLEAR_1); axi_rd(ADDR_MASK_0);
        axi_rd(ADDR_MASK_1); axi_rd(ADDR_SW_EN);
    endtask

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'h0;
        ev0 = 8'h00; ev1 = 8'h00; aresetn = 1'b0;
        err_total = 0; cmp_count = 0; en = 0;
        pm = '{0, 0}; mk = '{0, 0}; hold = '{0, 0};
        void'($urandom(90));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        #1 chk_state();
        rd_all();
        $display("test reset values done");
        // walking source through each bit, masks left closed so pending stays low
        for (i = 0; i < 8; i++)
        begin
            pulse(8'h01 << i, 8'h80 >> i);
            axi_rd(ADDR_CLEAR_0);
            axi_rd(ADDR_CLEAR_1);
        end
        axi_wr(ADDR_MASK_0, $urandom & 32'hff, 4'hf);
        axi_wr(ADDR_MASK_1, $urandom & 32'hff, 4'hf);
        $display("test source mapping done");
        // enable off: zeros clear, ones do nothing, clearing empty flags is harmless
        for (i = 0; i < 8; i++)
        begin
            pulse($urandom & 8'hff, $urandom & 8'hff);
            axi_wr((i % 2) ? ADDR_CLEAR_1 : ADDR_CLEAR_0, $urandom & 32'hff, 4'hf);
        end
        axi_wr(ADDR_CLEAR_0, 32'h0, 4'hf);
        axi_wr(ADDR_CLEAR_0, 32'h0, 4'hf);
        $display("test clear with enable off done");
        // enable on: ones post, zeros leave flags alone
        axi_wr(ADDR_SW_EN, 32'h1, 4'hf);
        for (i = 0; i < 8; i++)
        begin
            k = i % 2;
            axi_wr(k ? ADDR_CLEAR_1 : ADDR_CLEAR_0, 32'h1 << ($urandom % 8), 4'hf);
            axi_rd(k ? ADDR_CLEAR_1 : ADDR_CLEAR_0);
        end
        axi_wr(ADDR_CLEAR_1, 32'h0, 4'hf);
        axi_wr(ADDR_SW_EN, 32'h0, 4'hf);
        $display("test post with enable on done");
        // hardware event held across a clearing write must survive it
        @(posedge aclk);
        ev0 <= 8'h05;
        ev1 <= 8'h80;
        hold = '{5, 128};
        pm[0] |= 5;
        pm[1] |= 128;
        axi_wr(ADDR_CLEAR_0, 32'h0, 4'hf);
        axi_wr(ADDR_CLEAR_1, 32'h0, 4'hf);
        @(posedge aclk);
        ev0 <= 8'h00;
        ev1 <= 8'h00;
        hold = '{0, 0};
        axi_wr(ADDR_CLEAR_0, 32'h0, 4'hf);
        $display("test event against clear done");
        // unmapped places and a write without its low byte strobe
        axi_wr(12'h3fc, 32'hff, 4'hf);
        axi_rd(12'h3fc);
        axi_wr(ADDR_SW_EN, 32'h1, 4'he);
        rd_all();
        $display("test unmapped and strobe done");
        // reset again in mid-run: flags, masks and enable fall back to zero
        axi_wr(ADDR_SW_EN, 32'h1, 4'hf);
        pulse(8'hff, 8'hff);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        en = 0;
        pm = '{0, 0};
        mk = '{0, 0};
        #1 chk_state();
        rd_all();
        $display("test mid-run reset done");
        results();
    end
endmodule
